// File: asmc_pkg.sv
package asmc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;

	// Read timing
	localparam int unsigned READ_CYCLE_MIN_NS            = 70;
	localparam int unsigned ADDRESS_ACCESS_MAX_NS        = 70;
	localparam int unsigned OUTPUT_HOLD_AFTER_ADDRESS_NS = 10;
	localparam int unsigned SELECT_ACCESS_MAX_NS         = 70;
	localparam int unsigned OUTPUT_ENABLE_ACCESS_MAX_NS  = 35;
	localparam int unsigned OE_HIGH_TO_HIGHZ_MAX_NS      = 25;
	localparam int unsigned DESELECT_TO_STANDBY_MAX_NS   = 70;

	// Write timing
	localparam int unsigned WRITE_CYCLE_MIN_NS             = 70;
	localparam int unsigned SELECT_TO_WRITE_END_MIN_NS     = 60;
	localparam int unsigned ADDRESS_SETUP_TO_WRITE_END_NS  = 60;
	localparam int unsigned ADDRESS_HOLD_AFTER_WRITE_NS    = 0;
	localparam int unsigned ADDRESS_SETUP_TO_WRITE_START_NS = 0;
	localparam int unsigned WRITE_PULSE_WIDTH_MIN_NS       = 55;
	localparam int unsigned DATA_SETUP_TO_WRITE_END_NS     = 30;
	localparam int unsigned DATA_HOLD_AFTER_WRITE_NS       = 0;
	localparam int unsigned DESELECT_TO_RETENTION_NS       = 0;

	function automatic int unsigned ceil_cyc(input int unsigned ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : ceil_cyc

	function automatic int unsigned max2(input int unsigned a, input int unsigned b);
		return (a > b) ? a : b;
	endfunction : max2

	// Read: strobe window long enough for every access path; sampled at its own closing edge
	localparam int unsigned RD_ACCESS_CYC = max2(ceil_cyc(ADDRESS_ACCESS_MAX_NS),
		max2(ceil_cyc(SELECT_ACCESS_MAX_NS), ceil_cyc(OUTPUT_ENABLE_ACCESS_MAX_NS)));
	localparam int unsigned RD_CYCLE_CYC  = max2(ceil_cyc(READ_CYCLE_MIN_NS), RD_ACCESS_CYC);
	localparam int unsigned TURN_CYC      = max2(ceil_cyc(OE_HIGH_TO_HIGHZ_MAX_NS), 1);
	// Write: low pulse covers pulse width, select-to-end, address and data setup
	localparam int unsigned WR_PULSE_CYC  = max2(max2(ceil_cyc(WRITE_PULSE_WIDTH_MIN_NS),
		ceil_cyc(SELECT_TO_WRITE_END_MIN_NS)), max2(ceil_cyc(ADDRESS_SETUP_TO_WRITE_END_NS),
		ceil_cyc(DATA_SETUP_TO_WRITE_END_NS)));
	localparam int unsigned WR_CYCLE_CYC  = max2(ceil_cyc(WRITE_CYCLE_MIN_NS), WR_PULSE_CYC + 1);
	localparam int unsigned STANDBY_CYC   = max2(ceil_cyc(DESELECT_TO_STANDBY_MAX_NS), 1);
	localparam int unsigned CNT_W         = 4;

	localparam int unsigned ADDR_W = 19;
	localparam int unsigned DATA_W = 8;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asmc_req_type;

	typedef struct packed {
		logic cs_n;
		logic oe_n;
		logic we_n;
	} asmc_ctl_type;

	typedef enum logic [2:0] {
		ASMC_IDLE  = 3'b000,
		ASMC_RD    = 3'b001,
		ASMC_RTURN = 3'b011,
		ASMC_WR    = 3'b010,
		ASMC_WREC  = 3'b110
	} asmc_state_type;
endpackage : asmc_pkg

// File: asmc_host.sv
module asmc_host #(
	parameter int unsigned ADDR_W = asmc_pkg::ADDR_W,
	parameter int unsigned DATA_W = asmc_pkg::DATA_W
) (
	input  wire logic                 MCLK,
	input  wire logic                 RSTN,
	input  wire logic                 REQ_VALID,
	output logic                      REQ_READY,
	input  wire asmc_pkg::asmc_req_type REQ,
	output logic                      RD_VALID,
	output logic [DATA_W-1:0]         RD_DATA,
	output logic [ADDR_W-1:0]         MEM_ADDR,
	output logic                      MEM_CS_N,
	output logic                      MEM_OE_N,
	output logic                      MEM_WE_N,
	input  wire logic [DATA_W-1:0]    MEM_DQ_I,
	output logic [DATA_W-1:0]         MEM_DQ_O,
	output logic                      MEM_DQ_OE
);
	localparam logic [asmc_pkg::CNT_W-1:0] RD_LAST = asmc_pkg::CNT_W'(asmc_pkg::RD_CYCLE_CYC - 1);
	localparam logic [asmc_pkg::CNT_W-1:0] RT_LAST = asmc_pkg::CNT_W'(asmc_pkg::TURN_CYC - 1);
	localparam logic [asmc_pkg::CNT_W-1:0] WP_LAST = asmc_pkg::CNT_W'(asmc_pkg::WR_PULSE_CYC - 1);
	localparam logic [asmc_pkg::CNT_W-1:0] WR_LAST =
		asmc_pkg::CNT_W'(asmc_pkg::WR_CYCLE_CYC - asmc_pkg::WR_PULSE_CYC - 1);
	// Shortest write-enable low time that still covers the address setup
	localparam logic [asmc_pkg::CNT_W-1:0] WP_MIN =
		asmc_pkg::CNT_W'(asmc_pkg::ceil_cyc(asmc_pkg::ADDRESS_SETUP_TO_WRITE_END_NS));

	// The request struct fixes the widths; the phase counter must reach every phase
	if (ADDR_W != asmc_pkg::ADDR_W || DATA_W != asmc_pkg::DATA_W) begin : g_width_chk
		$error("asmc_host: widths must match the request struct");
	end
	if (asmc_pkg::RD_CYCLE_CYC >= 16 || asmc_pkg::WR_CYCLE_CYC >= 16) begin : g_cnt_chk
		$error("asmc_host: counter too narrow");
	end

	// True on the closing cycle of the named phase
	function automatic logic phase_done(
		input asmc_pkg::asmc_state_type st,
		input asmc_pkg::asmc_state_type want,
		input logic                     at_last
	);
		return at_last && (st == want);
	endfunction : phase_done

	asmc_pkg::asmc_state_type     state_q;
	logic [asmc_pkg::CNT_W-1:0]   cnt_q;
	asmc_pkg::asmc_ctl_type       ctl_q;
	logic [ADDR_W-1:0]            addr_q;
	logic [DATA_W-1:0]            wdata_q;
	logic                         dq_oe_q;
	logic [DATA_W-1:0]            rdata_q;
	logic                         rvalid_q;
	logic                         last;
	logic                         take;
	logic                         rd_done;
	logic                         wr_done;
	logic [asmc_pkg::CNT_W-1:0]   wr_low_q;

	assign REQ_READY = (state_q == asmc_pkg::ASMC_IDLE);
	assign last      = (state_q == asmc_pkg::ASMC_RD)    ? (cnt_q == RD_LAST) :
	                   (state_q == asmc_pkg::ASMC_RTURN) ? (cnt_q == RT_LAST) :
	                   (state_q == asmc_pkg::ASMC_WR)    ? (cnt_q == WP_LAST) :
	                   (state_q == asmc_pkg::ASMC_WREC)  ? (cnt_q == WR_LAST) : 1'b0;
	assign take      = REQ_VALID && REQ_READY;
	assign rd_done   = phase_done(state_q, asmc_pkg::ASMC_RD, last);
	assign wr_done   = phase_done(state_q, asmc_pkg::ASMC_WR, last);

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= asmc_pkg::ASMC_IDLE;
		end else begin
			unique case (state_q)
				asmc_pkg::ASMC_IDLE: begin
					if (REQ_VALID)
						state_q <= REQ.write ? asmc_pkg::ASMC_WR : asmc_pkg::ASMC_RD;
				end
				asmc_pkg::ASMC_RD:    if (last) state_q <= asmc_pkg::ASMC_RTURN;
				asmc_pkg::ASMC_RTURN: if (last) state_q <= asmc_pkg::ASMC_IDLE;
				asmc_pkg::ASMC_WR:    if (last) state_q <= asmc_pkg::ASMC_WREC;
				asmc_pkg::ASMC_WREC:  if (last) state_q <= asmc_pkg::ASMC_IDLE;
				default:              state_q <= asmc_pkg::ASMC_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_q <= '0;
		end else if (state_q == asmc_pkg::ASMC_IDLE || last) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Address and data latched with select, so both change at the same edge that opens the strobes
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_q  <= '0;
			wdata_q <= '0;
		end else if (take) begin
			addr_q  <= REQ.addr;
			wdata_q <= REQ.wdata;
		end
	end

	// All strobes rise together at the end; select low only during an access
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ctl_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else if (take) begin
			ctl_q <= '{cs_n: 1'b0, oe_n: REQ.write, we_n: !REQ.write};
		end else if (rd_done || wr_done) begin
			ctl_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end
	end

	// Drive only during a write; released at the same edge that ends it
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			dq_oe_q <= 1'b0;
		end else if (take) begin
			dq_oe_q <= REQ.write;
		end else if (wr_done) begin
			dq_oe_q <= 1'b0;
		end
	end

	// Sample at the closing edge of the read, after every access time has passed
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd_done;
			if (rd_done)
				rdata_q <= MEM_DQ_I;
		end
	end

	// Low time of write enable, kept only so the closing edge can be checked
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_low_q <= '0;
		end else if (MEM_WE_N) begin
			wr_low_q <= '0;
		end else if (wr_low_q != '1) begin
			wr_low_q <= wr_low_q + 1'b1;
		end
	end

	assign MEM_ADDR  = addr_q;
	assign MEM_CS_N  = ctl_q.cs_n;
	assign MEM_OE_N  = ctl_q.oe_n;
	assign MEM_WE_N  = ctl_q.we_n;
	assign MEM_DQ_O  = wdata_q;
	assign MEM_DQ_OE = dq_oe_q;
	assign RD_DATA   = rdata_q;
	assign RD_VALID  = rvalid_q;

	no_we_read_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		!MEM_OE_N |-> MEM_WE_N) else $error("write enable low during read");
	no_contend_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		MEM_DQ_OE |-> MEM_OE_N && $past(MEM_OE_N)) else $error("bus contention");
	we_needs_cs_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		!MEM_WE_N |-> !MEM_CS_N && MEM_DQ_OE) else $error("write without select or data");
	wr_pulse_len_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$fell(MEM_WE_N) |-> !MEM_WE_N [*3] ##1 MEM_WE_N) else $error("write pulse length");
	addr_stable_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		!MEM_CS_N && !$fell(MEM_CS_N) |-> $stable(MEM_ADDR)) else $error("address moved");
	wr_end_data_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> MEM_CS_N && !MEM_DQ_OE) else $error("write end mismatch");
	rd_len_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$fell(MEM_OE_N) |-> !MEM_OE_N [*4] ##1 MEM_OE_N ##0 RD_VALID) else $error("read length");
	idle_desel_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		REQ_READY |-> MEM_CS_N) else $error("selected while idle");
	wr_addr_setup_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> wr_low_q >= WP_MIN) else $error("write address setup short");
	wr_data_setup_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> $past(MEM_DQ_OE, 2)) else $error("write data setup short");
	wr_data_rel_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> $fell(MEM_DQ_OE)) else $error("write data not released");
	wr_addr_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> $stable(MEM_ADDR)) else $error("address moved at write end");
	wr_data_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		MEM_DQ_OE && !$rose(MEM_DQ_OE) |-> $stable(MEM_DQ_O)) else $error("write data moved");
	wr_start_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$fell(MEM_WE_N) |-> $fell(MEM_CS_N)) else $error("write opened apart from select");
	wr_recover_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_WE_N) |-> MEM_CS_N ##1 MEM_CS_N) else $error("write cycle too short");
	rd_open_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$fell(MEM_OE_N) |-> $fell(MEM_CS_N)) else $error("read opened apart from select");
	rd_standby_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		RD_VALID |-> MEM_CS_N) else $error("select held after read");
	rd_addr_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		RD_VALID |-> $stable(MEM_ADDR)) else $error("address moved before sample");
	rd_only_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		!MEM_OE_N |-> !MEM_CS_N && MEM_WE_N && !MEM_DQ_OE) else $error("read mode broken");
	rd_turn_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$rose(MEM_OE_N) |-> !MEM_DQ_OE [*2]) else $error("turnaround too short");
endmodule : asmc_host

// File: asmc_sram_model.sv
module asmc_sram_model (
	input  wire logic [18:0] addr,
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out,
	output logic             dq_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic    [7:0]  mem [logic [18:0]];
	logic    [18:0] addr_d;
	logic    [7:0]  dq_d;
	logic           wr;
	logic           standby;
	realtime        t_a;
	realtime        t_c;
	realtime        t_o;
	realtime        t_d;
	// Delayed copies let the end edge see values from before a zero-hold change
	assign #1 addr_d = addr;
	assign #1 dq_d = dq_in;
	assign wr = !cs_n && !we_n;
	assign standby = cs_n;
	initial dq_out = 8'h00;
	always @(addr) t_a = $realtime;
	always @(negedge cs_n) t_c = $realtime;
	always @(negedge oe_n) t_o = $realtime;
	always @(dq_d) t_d = $realtime;
	// Data short of setup is stored as unknown so a later read exposes it
	always @(negedge wr) mem[addr_d] = ($realtime - t_d >= 29) ? dq_d : 8'hxx;
	// Polled every ns so each access time runs from the latest edge
	always #1 begin
		dq_drv = !cs_n && !oe_n && we_n;
		if ($realtime - t_a >= 70 && $realtime - t_c >= 70 && $realtime - t_o >= 35)
			dq_out = mem.exists(addr) ? mem[addr] : 8'h00;
		else if ($realtime - t_a >= 10)
			dq_out = ~dq_out;
	end
endmodule : asmc_sram_model

// File: asmc_host_tb.sv
module asmc_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   mclk      = 1'b0;
	logic                   rstn      = 1'b0;
	logic                   req_valid = 1'b0;
	asmc_pkg::asmc_req_type req       = '0;
	logic                   req_ready, rd_valid, cs_n, oe_n, we_n, dq_oe, m_drv;
	logic [7:0]             rd_data, dq_o, m_out, bus;
	logic [7:0]             bus_q     = 8'h00;
	logic [18:0]            addr;
	int                     err_total = 0;
	int                     compares  = 0;
	asmc_pkg::asmc_req_type rows [8]  = '{
		{1'b1, 19'h0_0000, 8'hA5}, {1'b1, 19'h7_FFFF, 8'h3C},
		{1'b0, 19'h0_0000, 8'hA5}, {1'b1, 19'h1_2345, 8'hFF},
		{1'b0, 19'h1_2345, 8'hFF}, {1'b0, 19'h7_FFFF, 8'h3C},
		{1'b1, 19'h0_0000, 8'h5A}, {1'b0, 19'h0_0000, 8'h5A}};
	always #10 mclk = ~mclk;
	// Floating bus shows a value that changes every cycle
	assign bus = dq_oe ? dq_o : (m_drv ? m_out : ~bus_q);
	// An unknown start would otherwise keep the floating bus unknown for good
	always @(posedge mclk) bus_q <= $isunknown(bus) ? 8'h00 : bus;
	asmc_host asmc_host_i (.MCLK(mclk), .RSTN(rstn), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ(req), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.MEM_ADDR(addr), .MEM_CS_N(cs_n), .MEM_OE_N(oe_n), .MEM_WE_N(we_n),
		.MEM_DQ_I(bus), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe));
	asmc_sram_model asmc_sram_model_i (.addr(addr), .cs_n(cs_n), .oe_n(oe_n),
		.we_n(we_n), .dq_in(bus), .dq_out(m_out), .dq_drv(m_drv));
	task automatic chk(input logic bad, input string m);
		compares++;
		if (bad !== 1'b0) begin
			err_total++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic issue(input asmc_pkg::asmc_req_type r);
		int k;
		@(negedge mclk);
		req = r;
		req_valid = 1'b1;
		k = 0;
		while (req_ready !== 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		chk(k >= 20, "request never taken");
		@(posedge mclk);
		for (k = 1; k <= 8; k++) begin
			@(negedge mclk);
			req_valid = 1'b0;
			if (rd_valid === 1'b1) break;
		end
		chk(k != (r.write ? 9 : 5), "read valid timing");
		if (!r.write) chk(rd_data !== r.wdata, "read data");
	endtask : issue
	task report_and_stop;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	always @(negedge mclk) if (rstn) begin
		if (!cs_n && !oe_n) chk(we_n !== 1'b1, "write enable low in read");
		if (dq_oe) chk(m_drv !== 1'b0, "bus contention");
	end
	initial begin
		#(20 * 1000);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		foreach (rows[i]) issue(rows[i]);
		// Reset lands in the middle of a write pulse
		@(negedge mclk);
		req = {1'b1, 19'h0_0001, 8'h77};
		req_valid = 1'b1;
		repeat (3) @(negedge mclk);
		rstn = 1'b0;
		req_valid = 1'b0;
		#1;
		chk({cs_n, we_n, oe_n, dq_oe, req_ready} !== 5'h1D, "reset outputs");
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		issue({1'b0, 19'h0_0000, 8'h5A});
		chk(cs_n !== 1'b1, "idle select");
		report_and_stop();
	end
endmodule : asmc_host_tb
